// [hdl/fractional_pll_clock_generator.sv]
// register file, reference selection, loop coefficients and divider tree of the clock generator
module fractional_pll_clock_generator (
    input wire logic i_mclk,
    input wire logic i_reset_n,
    input wire logic [7:0] i_reg_page,
    input wire logic [7:0] i_reg_addr,
    input wire logic [7:0] i_reg_wdata,
    input wire logic i_reg_write,
    input wire logic i_reg_read,
    input wire logic i_master_clock_pin,
    input wire logic i_bit_clock_pin,
    input wire logic i_gpio_ref_pin,
    input wire logic i_loop_vco_out,
    input wire logic i_clock_master,
    input wire logic i_standby,
    input wire logic [7:0] i_modulator_divide_value,
    input wire logic [7:0] i_oversample_divide_value,
    input wire logic [7:0] i_charge_pump_divide_value,
    output logic [7:0] o_reg_rdata,
    output logic o_loop_enable,
    output logic o_loop_reference_in,
    output logic [3:0] o_pre_divide,
    output logic [4:0] o_post_mult,
    output logic [5:0] o_integer_mult,
    output logic [13:0] o_fraction_mult,
    output logic [23:0] o_loop_numerator,
    output logic o_coefficient_error,
    output logic o_rate_mismatch_possible,
    output logic o_processor_clock,
    output logic o_modulator_clock,
    output logic o_oversample_clock,
    output logic o_charge_pump_clock,
    output logic o_sample_rate_clock,
    output logic o_bit_clock_out,
    output logic o_bit_clock_oe,
    output logic o_word_clock_out,
    output logic o_word_clock_oe
);
    import clock_gen_pkg::*;

    function automatic logic [RATIO_WIDTH-1:0] to_ratio(input logic [7:0] value);
        // a zero divide value would stall the counter, so it runs as one
        to_ratio = (value == 8'h00) ? 12'h001 : {4'h0, value};
    endfunction : to_ratio

    function automatic logic [RATIO_WIDTH-1:0] plus_one(input logic [7:0] field);
        plus_one = {4'h0, field} + 12'h001;
    endfunction : plus_one

    ////////////////////////////////////////////////////////////////////////
    // configuration registers

    logic loop_on_bit;
    ref_source_type ref_source_field;
    logic [3:0] pre_divide_field;
    logic [5:0] integer_mult_field;
    logic [13:0] fraction_mult_field;
    logic [3:0] post_mult_field;
    logic [6:0] processor_divide_field;
    logic [6:0] bitclk_out_divide_field;
    logic [7:0] wordclk_out_divide_field;
    logic page_hit;

    assign page_hit = (i_reg_page == PAGE_CONFIG);

    always_ff @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            loop_on_bit <= loop_on_bit_reset;
            ref_source_field <= ref_source_type'(REF_SOURCE_RESET);
            pre_divide_field <= PRE_DIVIDE_RESET;
            integer_mult_field <= INTEGER_MULT_RESET;
            fraction_mult_field <= FRACTION_RESET;
            post_mult_field <= POST_MULT_RESET;
            processor_divide_field <= DIVIDE_RESET[6:0];
            bitclk_out_divide_field <= DIVIDE_RESET[6:0];
            wordclk_out_divide_field <= DIVIDE_RESET;
        end else if (i_reg_write && page_hit) begin
            unique case (i_reg_addr)
                ADDR_PLL_ON: loop_on_bit <= i_reg_wdata[LOOP_ON_POS];
                ADDR_REF_SOURCE: ref_source_field <= ref_source_type'(i_reg_wdata[REF_SOURCE_MSB:REF_SOURCE_LSB]);
                ADDR_PRE_DIVIDE: pre_divide_field <= i_reg_wdata[PRE_DIVIDE_MSB:0];
                ADDR_INTEGER_MULT: integer_mult_field <= i_reg_wdata[INTEGER_MULT_MSB:0];
                ADDR_FRACTION_HIGH: fraction_mult_field[13:8] <= i_reg_wdata[FRACTION_HIGH_MSB:0];
                ADDR_FRACTION_LOW: fraction_mult_field[7:0] <= i_reg_wdata;
                ADDR_POST_MULT: post_mult_field <= i_reg_wdata[POST_MULT_MSB:0];
                ADDR_PROCESSOR_DIVIDE: processor_divide_field <= i_reg_wdata[PROCESSOR_DIVIDE_MSB:0];
                ADDR_BITCLK_DIVIDE: bitclk_out_divide_field <= i_reg_wdata[BITCLK_DIVIDE_MSB:0];
                ADDR_WORDCLK_DIVIDE: wordclk_out_divide_field <= i_reg_wdata;
                default: ;
            endcase
        end
    end

    always_ff @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_reg_rdata <= 8'h00;
        end else if (i_reg_read) begin
            // unmapped addresses and other pages read zero
            if (!page_hit) begin
                o_reg_rdata <= 8'h00;
            end else begin
                unique case (i_reg_addr)
                    ADDR_PLL_ON: o_reg_rdata <= {7'h00, loop_on_bit};
                    ADDR_REF_SOURCE: o_reg_rdata <= {1'b0, ref_source_field, 4'h0};
                    ADDR_PRE_DIVIDE: o_reg_rdata <= {4'h0, pre_divide_field};
                    ADDR_INTEGER_MULT: o_reg_rdata <= {2'h0, integer_mult_field};
                    ADDR_FRACTION_HIGH: o_reg_rdata <= {2'h0, fraction_mult_field[13:8]};
                    ADDR_FRACTION_LOW: o_reg_rdata <= fraction_mult_field[7:0];
                    ADDR_POST_MULT: o_reg_rdata <= {4'h0, post_mult_field};
                    ADDR_PROCESSOR_DIVIDE: o_reg_rdata <= {1'b0, processor_divide_field};
                    ADDR_BITCLK_DIVIDE: o_reg_rdata <= {1'b0, bitclk_out_divide_field};
                    ADDR_WORDCLK_DIVIDE: o_reg_rdata <= wordclk_out_divide_field;
                    default: o_reg_rdata <= 8'h00;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers: 0 master, 1 bit clock, 2 gpio, 3 loop output

    logic [3:0] pin_raw;
    logic [2:0] pin_sync [4];
    logic [3:0] pin_level;
    logic [3:0] pin_level_d;
    logic [3:0] pin_rise;

    assign pin_raw = {i_loop_vco_out, i_gpio_ref_pin, i_bit_clock_pin, i_master_clock_pin};
    assign pin_rise = pin_level & ~pin_level_d;

    always_ff @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            for (int k = 0; k < 4; k++) begin
                pin_sync[k] <= 3'h0;
            end
            pin_level <= 4'h0;
            pin_level_d <= 4'h0;
        end else begin
            for (int k = 0; k < 4; k++) begin
                pin_sync[k] <= {pin_sync[k][1:0], pin_raw[k]};
                // stage 0 feeds only stage 1; level moves when stages 1 and 2 agree
                if (pin_sync[k][2] == pin_sync[k][1]) begin
                    pin_level[k] <= pin_sync[k][1];
                end
            end
            pin_level_d <= pin_level;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // loop coefficients and reference

    logic [4:0] post_value;
    logic [3:0] pre_value;
    logic [13:0] fraction_value;
    logic [19:0] k_scaled;
    logic [23:0] next_numerator;
    logic next_coefficient_error;
    logic ref_level;

    always_comb begin
        // R field maps 0..15 onto 1..16, P field zero runs as one
        post_value = {1'b0, post_mult_field} + 5'h01;
        pre_value = (pre_divide_field == 4'h0) ? 4'h1 : pre_divide_field;
        fraction_value = (fraction_mult_field > FRACTION_MAX) ? FRACTION_MAX : fraction_mult_field;
        k_scaled = 20'(integer_mult_field * FRACTION_SCALE) + {6'h00, fraction_value};
        // numerator of reference x R x K, the loop divides by P
        next_numerator = 24'(k_scaled * post_value);
        // fractional limits on J and R
        if (fraction_value != 14'h0000) begin
            next_coefficient_error = (integer_mult_field < J_MIN_FRACTIONAL)
                || (integer_mult_field > J_MAX_FRACTIONAL) || (post_value != 5'h01);
        end else begin
            next_coefficient_error = (integer_mult_field < J_MIN_INTEGER);
        end
        unique case (ref_source_field)
            REF_BITCLK: ref_level = pin_level[1];
            REF_GPIO: ref_level = pin_level[2];
            default: ref_level = pin_level[0];
        endcase
    end

    always_ff @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_loop_enable <= 1'b0;
            o_loop_reference_in <= 1'b0;
            o_pre_divide <= 4'h1;
            o_post_mult <= 5'h01;
            o_integer_mult <= 6'h00;
            o_fraction_mult <= 14'h0000;
            o_loop_numerator <= 24'h000000;
            o_coefficient_error <= 1'b0;
            o_rate_mismatch_possible <= 1'b0;
        end else begin
            o_loop_enable <= loop_on_bit;
            o_loop_reference_in <= ref_level;
            o_pre_divide <= pre_value;
            o_post_mult <= post_value;
            o_integer_mult <= integer_mult_field;
            o_fraction_mult <= fraction_value;
            o_loop_numerator <= next_numerator;
            o_coefficient_error <= loop_on_bit && next_coefficient_error;
            // mismatch only as clock master with a fraction
            o_rate_mismatch_possible <= i_clock_master && loop_on_bit && (fraction_value != 14'h0000);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // divider tree

    divider_if div_bus [DIVIDER_COUNT] ();
    logic base_tick;

    // bypassed loop hands the tree to the master clock pin
    assign base_tick = loop_on_bit ? pin_rise[3] : pin_rise[0];

    // processor and modulator clocks from loop output
    assign div_bus[DIV_PROCESSOR].src_tick = base_tick;
    assign div_bus[DIV_PROCESSOR].ratio = plus_one({1'b0, processor_divide_field});
    assign div_bus[DIV_MODULATOR].src_tick = base_tick;
    assign div_bus[DIV_MODULATOR].ratio = to_ratio(i_modulator_divide_value);
    assign div_bus[DIV_OVERSAMPLE].src_tick = div_bus[DIV_MODULATOR].out_tick;
    assign div_bus[DIV_OVERSAMPLE].ratio = to_ratio(i_oversample_divide_value);
    assign div_bus[DIV_CHARGE_PUMP].src_tick = div_bus[DIV_MODULATOR].out_tick;
    assign div_bus[DIV_CHARGE_PUMP].ratio = to_ratio(i_charge_pump_divide_value);
    assign div_bus[DIV_BITCLK].src_tick = base_tick;
    assign div_bus[DIV_BITCLK].ratio = plus_one({1'b0, bitclk_out_divide_field});
    assign div_bus[DIV_WORDCLK].src_tick = div_bus[DIV_BITCLK].out_tick;
    assign div_bus[DIV_WORDCLK].ratio = plus_one(wordclk_out_divide_field);
    // sample rate is loop output over 2048
    assign div_bus[DIV_SAMPLE].src_tick = base_tick;
    assign div_bus[DIV_SAMPLE].ratio = SAMPLE_RATIO;

    genvar g;
    generate
        for (g = 0; g < DIVIDER_COUNT; g++) begin : gen_div
            // standby holds every divider at its start
            assign div_bus[g].hold = i_standby;
            clock_divider u_div (
                .i_mclk(i_mclk),
                .i_reset_n(i_reset_n),
                .bus(div_bus[g])
            );
        end
    endgenerate

    always_ff @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_processor_clock <= 1'b0;
            o_modulator_clock <= 1'b0;
            o_oversample_clock <= 1'b0;
            o_charge_pump_clock <= 1'b0;
            o_sample_rate_clock <= 1'b0;
            o_bit_clock_out <= 1'b0;
            o_word_clock_out <= 1'b0;
            o_bit_clock_oe <= 1'b0;
            o_word_clock_oe <= 1'b0;
        end else begin
            o_processor_clock <= div_bus[DIV_PROCESSOR].out_clk;
            o_modulator_clock <= div_bus[DIV_MODULATOR].out_clk;
            o_oversample_clock <= div_bus[DIV_OVERSAMPLE].out_clk;
            o_charge_pump_clock <= div_bus[DIV_CHARGE_PUMP].out_clk;
            o_sample_rate_clock <= div_bus[DIV_SAMPLE].out_clk;
            // audio clocks driven out only as clock master
            o_bit_clock_out <= i_clock_master && div_bus[DIV_BITCLK].out_clk;
            o_word_clock_out <= i_clock_master && div_bus[DIV_WORDCLK].out_clk;
            o_bit_clock_oe <= i_clock_master;
            o_word_clock_oe <= i_clock_master;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks

    logic reset_seen;
    always_ff @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            reset_seen <= 1'b1;
        end else begin
            reset_seen <= 1'b0;
        end
    end

    chk_loop_on_reset: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
        reset_seen |-> loop_on_bit)
        else $error("loop not enabled after reset");
    chk_loop_on_write: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
        (i_reg_write && page_hit && i_reg_addr == ADDR_PLL_ON) |=> ##1 (o_loop_enable == $past(i_reg_wdata[0], 2)))
        else $error("loop enable output does not follow its bit");
    chk_ref_select: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
        (ref_source_field == REF_BITCLK) |=> (o_loop_reference_in == $past(pin_level[1])))
        else $error("reference mux picked the wrong source");
    chk_numerator_value: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
        $stable(integer_mult_field) && $stable(post_mult_field) && $stable(fraction_mult_field)
        |=> o_loop_numerator == 24'((24'($past(integer_mult_field)) * 24'd10000 + 24'($past(fraction_value)))
            * 24'($past(post_value))))
        else $error("loop numerator wrong");
    chk_fraction_range: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
        o_fraction_mult <= FRACTION_MAX)
        else $error("fraction beyond 9999");
    chk_post_range: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
        (o_post_mult >= 5'h01) && (o_post_mult <= 5'h10) && (o_pre_divide != 4'h0))
        else $error("post or pre divide out of range");
    chk_fraction_error: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
        (loop_on_bit && fraction_value != 14'h0000 && post_value != 5'h01) |=> o_coefficient_error)
        else $error("fractional R not flagged");
    chk_slave_quiet: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
        !i_clock_master |=> (!o_bit_clock_oe && !o_word_clock_oe && !o_rate_mismatch_possible))
        else $error("audio clocks driven while slave");
    chk_bypass_tick: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
        (!loop_on_bit && !i_standby && pin_rise[0] && div_bus[DIV_MODULATOR].ratio == 12'h001)
        |=> div_bus[DIV_MODULATOR].out_tick)
        else $error("bypass does not clock the tree from master clock");
    chk_read_back: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
        (i_reg_read && page_hit && i_reg_addr == ADDR_POST_MULT) |=> (o_reg_rdata == {4'h0, $past(post_mult_field)}))
        else $error("post field read back wrong");

    cov_fraction_mode: cover property (@(posedge i_mclk) disable iff (!i_reset_n)
        loop_on_bit && fraction_value != 14'h0000 && !next_coefficient_error);
    cov_bypass: cover property (@(posedge i_mclk) disable iff (!i_reset_n)
        !loop_on_bit && div_bus[DIV_PROCESSOR].out_tick);
    cov_master_word: cover property (@(posedge i_mclk) disable iff (!i_reset_n)
        i_clock_master && $rose(o_word_clock_out));
endmodule : fractional_pll_clock_generator

// [inc/clock_gen_pkg.sv]
// constants, register map and field layout of the clock generator
// Overview of operation
// - three-bit reference field picks bit clock, master clock or general-purpose pin.
// - loop enable bit; cleared bypasses loop, external master clock then feeds internal clocks.
// - loop enable bit is set out of reset.
// - loop output is reference times R times K, divided by P.
// - K is integer J (1 to 63) plus fraction D in ten-thousandths.
// - P programmable 1 to 15, R programmable 1 to 16, with J and D.
// - sample rate is reference times K times R over 2048 times P.
// - P, J, D high, D low and R sit at registers 20 to 24.
// - seven-bit processor divider, seven-bit bit clock divider, eight-bit word clock divider.
// - processor and modulator clocks are loop output over their dividers.
// - charge-pump clock is modulator clock over its divider.
// - rate mismatch can arise only while the device is audio clock master.
package clock_gen_pkg;
    localparam logic [7:0] PAGE_CONFIG = 8'h00;
    localparam logic [7:0] ADDR_PLL_ON = 8'h04;
    localparam logic [7:0] ADDR_REF_SOURCE = 8'h0d;
    localparam logic [7:0] ADDR_PRE_DIVIDE = 8'h14;
    localparam logic [7:0] ADDR_INTEGER_MULT = 8'h15;
    localparam logic [7:0] ADDR_FRACTION_HIGH = 8'h16;
    localparam logic [7:0] ADDR_FRACTION_LOW = 8'h17;
    localparam logic [7:0] ADDR_POST_MULT = 8'h18;
    localparam logic [7:0] ADDR_PROCESSOR_DIVIDE = 8'h1b;
    localparam logic [7:0] ADDR_BITCLK_DIVIDE = 8'h20;
    localparam logic [7:0] ADDR_WORDCLK_DIVIDE = 8'h21;
    localparam int LOOP_ON_POS = 0;
    localparam int REF_SOURCE_LSB = 4;
    localparam int REF_SOURCE_MSB = 6;
    localparam int PRE_DIVIDE_MSB = 3;
    localparam int INTEGER_MULT_MSB = 5;
    localparam int FRACTION_HIGH_MSB = 5;
    localparam int POST_MULT_MSB = 3;
    localparam int PROCESSOR_DIVIDE_MSB = 6;
    localparam int BITCLK_DIVIDE_MSB = 6;
    localparam logic loop_on_bit_reset = 1'b1;
    localparam logic [2:0] REF_SOURCE_RESET = 3'h0;
    localparam logic [3:0] PRE_DIVIDE_RESET = 4'h1;
    localparam logic [5:0] INTEGER_MULT_RESET = 6'h08;
    localparam logic [13:0] FRACTION_RESET = 14'h0000;
    localparam logic [3:0] POST_MULT_RESET = 4'h0;
    localparam logic [7:0] DIVIDE_RESET = 8'h00;
    localparam logic [13:0] FRACTION_MAX = 14'h270f;
    localparam logic [19:0] FRACTION_SCALE = 20'h02710;
    localparam logic [5:0] J_MIN_FRACTIONAL = 6'h04;
    localparam logic [5:0] J_MAX_FRACTIONAL = 6'h0b;
    localparam logic [5:0] J_MIN_INTEGER = 6'h01;
    localparam logic [11:0] SAMPLE_RATIO = 12'h800;
    localparam int RATIO_WIDTH = 12;
    localparam int DIVIDER_COUNT = 7;
    localparam int DIV_PROCESSOR = 0;
    localparam int DIV_MODULATOR = 1;
    localparam int DIV_OVERSAMPLE = 2;
    localparam int DIV_CHARGE_PUMP = 3;
    localparam int DIV_BITCLK = 4;
    localparam int DIV_WORDCLK = 5;
    localparam int DIV_SAMPLE = 6;
    typedef enum logic [2:0] {
        REF_MASTER = 3'b000,
        REF_BITCLK = 3'b001,
        REF_GPIO = 3'b010
    } ref_source_type;
endpackage : clock_gen_pkg

// [inc/divider_if.sv]
// carrier between the generator and one of its counting dividers
interface divider_if;
    logic src_tick;
    logic hold;
    logic [clock_gen_pkg::RATIO_WIDTH-1:0] ratio;
    logic out_tick;
    logic out_clk;
    modport div (input src_tick, input hold, input ratio, output out_tick, output out_clk);
    modport ctl (output src_tick, output hold, output ratio, input out_tick, input out_clk);
endinterface : divider_if

// [hdl/clock_divider.sv]
// counting divider: one output period per ratio source ticks
module clock_divider (
    input wire logic i_mclk,
    input wire logic i_reset_n,
    divider_if.div bus
);
    import clock_gen_pkg::*;

    logic [RATIO_WIDTH-1:0] count;
    logic [RATIO_WIDTH-1:0] next_count;
    logic [RATIO_WIDTH-1:0] high_len;
    logic wrap;

    always_comb begin
        wrap = (count >= bus.ratio - 1'b1);
        next_count = wrap ? '0 : count + 1'b1;
        // odd ratios get the longer half high
        high_len = bus.ratio - (bus.ratio >> 1);
    end

    always_ff @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            count <= '0;
            bus.out_clk <= 1'b0;
            bus.out_tick <= 1'b0;
        end else if (bus.hold) begin
            count <= '0;
            bus.out_clk <= 1'b0;
            bus.out_tick <= 1'b0;
        end else if (bus.src_tick) begin
            count <= next_count;
            bus.out_clk <= (next_count < high_len);
            bus.out_tick <= wrap;
        end else begin
            bus.out_tick <= 1'b0;
        end
    end

    chk_tick_one_cycle: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
        bus.out_tick |=> !bus.out_tick)
        else $error("divider tick lasted more than one cycle");
    chk_hold_quiet: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
        bus.hold |=> (!bus.out_tick && !bus.out_clk))
        else $error("divider active while held");
endmodule : clock_divider

// [tb/clock_source.sv]
// external oscillator returning the loop output to the generator
module clock_source (
    input wire logic i_mclk,
    input wire logic i_run,
    output logic o_vco
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [1:0] phase = 2'h0;
    always @(posedge i_mclk) begin
        phase <= i_run ? phase + 2'h1 : 2'h0;
        o_vco <= i_run & phase[1];
    end
endmodule : clock_source

// [tb/fractional_pll_clock_generator_tb.sv]
// self-checking bench of the clock generator
module fractional_pll_clock_generator_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import clock_gen_pkg::*;
    logic i_mclk = 1'b0;
    logic i_reset_n = 1'b0;
    logic [7:0] pg = 8'h00, addr = 8'h00, wdata = 8'h00, mdiv = 8'h04, rdata;
    logic wr_s = 1'b0, rd_s = 1'b0, rd_d = 1'b0, master = 1'b0, stby = 1'b0;
    logic [2:0] pins = 3'h0;
    logic [7:0] osr = 8'h20, charge_pump_divide_value = 8'h04;
    logic [1:0] oe;
    logic vco, ref_in, lp_en, cerr, mism, pclk, mclk_o;
    logic [3:0] p_o;
    logic [4:0] r_o;
    logic [5:0] j_o;
    logic [13:0] d_o, dv;
    logic [23:0] num;
    logic [31:0] lfsr = 32'h32a6;
    logic [7:0] q[$];
    int error_cnt = 0, check_count = 0;
    always #50 i_mclk = ~i_mclk;
    clock_source i_src (.i_mclk(i_mclk), .i_run(1'b1), .o_vco(vco));
    fractional_pll_clock_generator i_dut (.i_mclk(i_mclk), .i_reset_n(i_reset_n), .i_reg_page(pg),
        .i_reg_addr(addr), .i_reg_wdata(wdata), .i_reg_write(wr_s), .i_reg_read(rd_s),
        .i_master_clock_pin(pins[0]), .i_bit_clock_pin(pins[1]), .i_gpio_ref_pin(pins[2]),
        .i_loop_vco_out(vco), .i_clock_master(master), .i_standby(stby), .i_modulator_divide_value(mdiv),
        .i_oversample_divide_value(osr), .i_charge_pump_divide_value(charge_pump_divide_value), .o_reg_rdata(rdata),
        .o_loop_enable(lp_en), .o_loop_reference_in(ref_in), .o_pre_divide(p_o), .o_post_mult(r_o),
        .o_integer_mult(j_o), .o_fraction_mult(d_o), .o_loop_numerator(num), .o_coefficient_error(cerr),
        .o_rate_mismatch_possible(mism), .o_processor_clock(pclk), .o_modulator_clock(mclk_o),
        .o_oversample_clock(), .o_charge_pump_clock(), .o_sample_rate_clock(), .o_bit_clock_out(),
        .o_bit_clock_oe(oe[0]), .o_word_clock_out(), .o_word_clock_oe(oe[1]));
    function automatic logic [31:0] next_rand(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : next_rand
    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic final_report;
        $display("checks %0d errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : final_report
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_mclk);
        addr <= a;
        wdata <= d;
        wr_s <= 1'b1;
        @(posedge i_mclk);
        wr_s <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] p, input logic [7:0] a, input logic [7:0] e);
        @(posedge i_mclk);
        pg <= p;
        addr <= a;
        rd_s <= 1'b1;
        q.push_back(e);
        @(posedge i_mclk);
        rd_s <= 1'b0;
        pg <= 8'h00;
    endtask : rd
    task automatic settle(input int n);
        repeat (n) @(posedge i_mclk);
        #1;
    endtask : settle
    task automatic rises(input int n, input int ep, input int em);
        int np = 0;
        int nm = 0;
        logic lp = pclk;
        logic lm = mclk_o;
        repeat (n) begin
            settle(1);
            np += int'(pclk & ~lp);
            nm += int'(mclk_o & ~lm);
            lp = pclk;
            lm = mclk_o;
        end
        chk(24'(np >= ep - 1 && np <= ep + 1 && nm >= em - 1 && nm <= em + 1), 24'h1);
        $display("test clock_tree done");
    endtask : rises
    // read data lands one cycle after the strobe
    always @(posedge i_mclk) begin
        rd_d <= rd_s;
        if (rd_d) chk(24'(rdata), 24'(q.pop_front()));
    end
    initial begin
        #500000;
        error_cnt++;
        $display("[FAIL] %0t watchdog expired", $time);
        final_report;
    end
    initial begin
        repeat (5) @(posedge i_mclk);
        i_reset_n <= 1'b1;
        settle(2);
        chk(24'(lp_en), 24'h1);
        chk(num, 24'd80000);
        chk(24'(oe), 24'h0);
        rd(8'h00, ADDR_PLL_ON, 8'h01);
        rd(8'h01, ADDR_PLL_ON, 8'h00);
        rd(8'h00, 8'h05, 8'h00);
        wr(ADDR_PROCESSOR_DIVIDE, 8'hff);
        wr(ADDR_BITCLK_DIVIDE, 8'hff);
        wr(ADDR_WORDCLK_DIVIDE, 8'hff);
        rd(8'h00, ADDR_PROCESSOR_DIVIDE, 8'h7f);
        rd(8'h00, ADDR_BITCLK_DIVIDE, 8'h7f);
        rd(8'h00, ADDR_WORDCLK_DIVIDE, 8'hff);
        $display("test register_map done");
        @(posedge i_mclk);
        stby <= 1'b1;
        lfsr = next_rand(lfsr);
        dv = {6'h04, lfsr[7:0]};
        wr(ADDR_PRE_DIVIDE, 8'h03);
        wr(ADDR_INTEGER_MULT, 8'h09);
        wr(ADDR_FRACTION_HIGH, 8'h04);
        wr(ADDR_FRACTION_LOW, lfsr[7:0]);
        settle(2);
        chk(24'(p_o), 24'h3);
        chk(24'(j_o), 24'h9);
        chk(24'(d_o), 24'(dv));
        chk(num, 24'd90000 + 24'(dv));
        chk(24'(cerr), 24'h0);
        wr(ADDR_POST_MULT, 8'h03);
        master <= 1'b1;
        settle(3);
        chk(24'(r_o), 24'h4);
        chk(num, 24'd4 * (24'd90000 + 24'(dv)));
        chk(24'({cerr, mism}), 24'h3);
        chk(24'(oe), 24'h3);
        wr(ADDR_PLL_ON, 8'h00);
        settle(2);
        chk(24'({lp_en, mism}), 24'h0);
        rd(8'h00, ADDR_FRACTION_LOW, lfsr[7:0]);
        $display("test coefficients done");
        for (int c = 0; c < 3; c++) begin
            wr(ADDR_REF_SOURCE, 8'(c << 4));
            pins <= 3'h1 << c;
            settle(6);
            chk(24'(ref_in), 24'h1);
            @(posedge i_mclk);
            pins <= ~(3'h1 << c);
            settle(6);
            chk(24'(ref_in), 24'h0);
        end
        $display("test reference_select done");
        wr(ADDR_PLL_ON, 8'h01);
        wr(ADDR_PROCESSOR_DIVIDE, 8'h01);
        wr(ADDR_POST_MULT, 8'h00);
        wr(ADDR_FRACTION_HIGH, 8'h00);
        wr(ADDR_FRACTION_LOW, 8'h00);
        stby <= 1'b0;
        settle(12);
        chk(24'({cerr, mism}), 24'h0);
        rises(160, 20, 10);
        @(posedge i_mclk);
        stby <= 1'b1;
        settle(4);
        rises(80, 0, 0);
        wr(ADDR_PLL_ON, 8'h00);
        mdiv <= 8'h01;
        stby <= 1'b0;
        repeat (8) begin
            @(posedge i_mclk);
            pins <= ~pins;
            settle(3);
        end
        chk(24'(mclk_o), 24'h1);
        $display("test bypass done");
        final_report;
    end
endmodule : fractional_pll_clock_generator_tb
